//--- shared/rnpc_pkg.sv
// rnpc_pkg: constants, enums and carrier structs for the reset / nmi / power-down controller
// assumes a single 100 MHz cpu clock; no software-visible register bus
package rnpc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int RST_FILTER_MIN_NS   = 100;                   // least low time for recognition
  localparam int RST_FILTER_EXTRA    = 2;                     // plus two cpu clocks
  localparam int RST_FILTER_CYC      = (RST_FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                       + RST_FILTER_EXTRA;
  localparam int RST_SEQ_CYC_DEF     = 64;                    // internal reset sequence length
  localparam int CNT_W               = 16;

  // reset cause encoding
  localparam logic [2:0] CAUSE_NONE    = 3'h0;
  localparam logic [2:0] CAUSE_HW_LONG = 3'h1;
  localparam logic [2:0] CAUSE_HW_SHRT = 3'h2;
  localparam logic [2:0] CAUSE_SW      = 3'h3;
  localparam logic [2:0] CAUSE_WDT     = 3'h4;

  // reset values
  localparam logic BIDIR_RST_VAL = 1'b0;
  localparam logic END_OF_INIT_INSTR_RST_VAL = 1'b0;

  typedef enum logic [1:0] {
    RNPC_RUN,
    RNPC_SEQ,
    RNPC_INIT,
    RNPC_PD
  } rnpc_state_t;

  // requests from the cpu core
  typedef struct packed {
    logic sw_reset;
    logic wdt_reset;
    logic power_down_instr;
    logic end_of_init_instr;
    logic bidir_wr;
    logic bidir_wdata;
  } rnpc_core_req_t;

  // status back to the cpu core
  typedef struct packed {
    logic       core_reset;
    logic       nmi_trap;
    logic       power_down;
    logic       bidir_reset_enable;
    logic       init_done;
    logic [2:0] reset_cause;
    logic       cfg_latch;
    logic       boot_loader;
  } rnpc_core_stat_t;

endpackage : rnpc_pkg

//--- core/rnpc_edge_filter.sv
// rnpc_edge_filter: qualifies a low level held for a number of clocks, flags falling edges
// assumes the input is already synchronous to sys_clk_in
`timescale 1ns/1ps
module rnpc_edge_filter #(
  parameter int CNT_W   = 16,
  parameter int MIN_CYC = 12
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  // sampled level
  input  wire logic level_in,
  // qualified results
  output logic      low_long_out,
  output logic      fall_out
);

  logic             prev;
  logic [CNT_W-1:0] low_cnt;

  // previous sample for edge detection
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev <= 1'b1;
    end else begin
      prev <= level_in;
    end
  end

  // saturating low-time counter; restarts on any high sample
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_cnt <= '0;
    end else if (level_in) begin
      low_cnt <= '0;
    end else if (low_cnt != CNT_W'(MIN_CYC)) begin
      low_cnt <= low_cnt + CNT_W'(1);
    end
  end

  assign low_long_out = (low_cnt == CNT_W'(MIN_CYC));
  assign fall_out     = prev & ~level_in;

endmodule : rnpc_edge_filter

//--- core/rnpc_reset_nmi_ctrl.sv
// rnpc_reset_nmi_ctrl: reset sequencing, reset indication, nmi trap and power-down gate
// assumes pin inputs are synchronous to sys_clk_in; the reset line is open drain outside
//
// Operation
// RULE_01: a low reset line, with the clock running, puts the device into reset.
// RULE_02: external source holds reset low at least 100 ns plus two clocks.
// RULE_03: bidirectional mode drives the reset line low through the whole internal sequence.
// RULE_04: reset indication is low during hardware, software or watchdog reset.
// RULE_05: reset indication stays low until end-of-init executes, then goes high.
// RULE_06: falling edge on nmi input raises the nmi trap request; the code raises it only in run or init state.
// RULE_07: power-down instruction enters power-down only when nmi input is low.
// RULE_08: with nmi high the power-down instruction is ignored, running continues.
// RULE_09: bidirectional enable bit is locked against writes after end-of-init.
// RULE_10: every reset clears the bidirectional enable bit.
// RULE_11: in bidirectional mode the reset cause always reads long hardware reset.
// RULE_12: in bidirectional mode startup configuration is latched as for hardware reset.
// RULE_13: in bidirectional mode a short external reset is stretched to full sequence.
// RULE_14: internal reset sequence length is a module parameter.
`timescale 1ns/1ps
module rnpc_reset_nmi_ctrl
  import rnpc_pkg::*;
#(
  parameter int SEQ_CYC = rnpc_pkg::RST_SEQ_CYC_DEF,
  parameter int MIN_CYC = rnpc_pkg::RST_FILTER_CYC
) (
  // clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      nrst_in,
  // reset line, open drain
  input  wire logic                      reset_in_line_in,
  output logic                           reset_in_line_out,
  output logic                           reset_in_line_oe_out,
  // indication, nmi and boot select pins
  output logic                           reset_indication_out,
  input  wire logic                      nmi_in,
  input  wire logic                      boot_select_pin_in,
  // core side
  input  wire rnpc_pkg::rnpc_core_req_t  core_req_in,
  output rnpc_pkg::rnpc_core_stat_t      core_stat_out
);
  import rnpc_pkg::*;

  rnpc_state_t      state;
  rnpc_state_t      next_state;
  logic [CNT_W-1:0] seq_cnt;
  logic             ext_long;
  logic             ext_low;
  logic             nmi_fall;
  logic             unused_rst_fall;
  logic             bidir;
  logic             init_done;
  logic             nmi_trap;
  logic [2:0]       cause;
  logic             cfg_latch;
  logic             boot_loader;
  logic             seq_start;
  logic [2:0]       start_cause;
  logic             seq_end;
  logic             drive_low;
  logic             oe_q;

  // reset line qualification; short pulses only count when stretched
  rnpc_edge_filter #(
    .CNT_W   (CNT_W),
    .MIN_CYC (MIN_CYC)
  ) u_rst_filt (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .level_in     (reset_in_line_in),
    .low_long_out (ext_long),
    .fall_out     (unused_rst_fall)
  );

  // nmi edge detector, single-cycle low counts as edge
  rnpc_edge_filter #(
    .CNT_W   (CNT_W),
    .MIN_CYC (1)
  ) u_nmi_filt (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .level_in     (nmi_in),
    .low_long_out (),
    .fall_out     (nmi_fall)
  );

  assign ext_low = ~reset_in_line_in;

  // our own drive of the line must not retrigger the sequence it is part of;
  // the filter still holds its low count for one cycle after the drive ends
  assign drive_low = reset_in_line_oe_out || oe_q;

  // pick a reset source; hardware wins over software and watchdog
  always_comb begin
    seq_start   = 1'b0;
    start_cause = CAUSE_NONE;
    if (ext_long && !drive_low) begin
      seq_start   = 1'b1;                                       // RULE_01
      start_cause = CAUSE_HW_LONG;
    end else if (bidir && ext_low && !drive_low && state != RNPC_SEQ) begin
      seq_start   = 1'b1;                                       // RULE_13
      start_cause = CAUSE_HW_SHRT;
    end else if (core_req_in.sw_reset) begin
      seq_start   = 1'b1;
      start_cause = CAUSE_SW;
    end else if (core_req_in.wdt_reset) begin
      seq_start   = 1'b1;
      start_cause = CAUSE_WDT;
    end
  end

  assign seq_end = (state == RNPC_SEQ) && (seq_cnt == CNT_W'(SEQ_CYC - 1));

  // sequence state machine
  always_comb begin
    next_state = state;
    case (state)
      RNPC_RUN: begin
        if (core_req_in.power_down_instr && !nmi_in) begin
          next_state = RNPC_PD;                                 // RULE_07
        end
      end
      RNPC_SEQ: begin
        if (seq_end && !(ext_long && !drive_low)) begin
          next_state = RNPC_INIT;
        end
      end
      RNPC_INIT: begin
        if (core_req_in.end_of_init_instr) begin
          next_state = RNPC_RUN;                                // RULE_05
        end
      end
      RNPC_PD: begin
        next_state = RNPC_PD;                                   // left only by reset
      end
      default: begin
        next_state = RNPC_SEQ;
      end
    endcase
    if (seq_start) begin
      next_state = RNPC_SEQ;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= RNPC_SEQ;
    end else begin
      state <= next_state;
    end
  end

  // sequence length counter; restarts on every new reset source
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_cnt <= '0;
    end else if (seq_start || state != RNPC_SEQ) begin
      seq_cnt <= '0;
    end else if (!seq_end) begin
      seq_cnt <= seq_cnt + CNT_W'(1);                          // RULE_14
    end
  end

  // bidirectional enable: cleared by any reset, frozen after end-of-init
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bidir <= BIDIR_RST_VAL;
    end else if (seq_start) begin
      bidir <= BIDIR_RST_VAL;                                   // RULE_10
    end else if (core_req_in.bidir_wr && !init_done) begin
      bidir <= core_req_in.bidir_wdata;                         // RULE_09
    end
  end

  // init-done flag tracks end-of-init since last reset
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_done <= END_OF_INIT_INSTR_RST_VAL;
    end else if (seq_start) begin
      init_done <= END_OF_INIT_INSTR_RST_VAL;
    end else if (state == RNPC_INIT && core_req_in.end_of_init_instr) begin
      init_done <= 1'b1;
    end
  end

  // reset cause flags; bidirectional mode reports long hardware reset
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cause <= CAUSE_HW_LONG;
    end else if (seq_start) begin
      cause <= (bidir || reset_in_line_oe_out) ? CAUSE_HW_LONG : start_cause; // RULE_11
    end
  end

  // startup configuration latch at end of sequence
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_latch   <= 1'b0;
      boot_loader <= 1'b0;
    end else begin
      cfg_latch <= seq_end;
      if (seq_end && (cause == CAUSE_HW_LONG || cause == CAUSE_HW_SHRT)) begin
        boot_loader <= ~boot_select_pin_in;                     // RULE_12
      end else if (seq_start) begin
        boot_loader <= 1'b0;
      end
    end
  end

  // nmi trap request: one pulse per falling edge, only in run or init state
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nmi_trap <= 1'b0;
    end else begin
      nmi_trap <= nmi_fall && (state == RNPC_RUN || state == RNPC_INIT); // RULE_06
    end
  end

  // reset indication low from sequence start until end-of-init
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_indication_out <= 1'b0;
    end else begin
      reset_indication_out <= (next_state == RNPC_RUN || next_state == RNPC_PD); // RULE_04 RULE_05
    end
  end

  // open drain drive of the reset line; registered to avoid glitches
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_in_line_oe_out <= 1'b0;
    end else begin
      reset_in_line_oe_out <= bidir_next_drive(next_state, bidir && seq_start,
                                               reset_in_line_oe_out && (state == RNPC_SEQ)); // RULE_03
    end
  end

  // delayed copy of the drive; masks the stale low count after release
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= reset_in_line_oe_out;
    end
  end

  // drive starts with a sequence begun in bidir mode and lasts until it ends;
  // the enable bit is already cleared by then, so the drive holds itself
  function automatic logic bidir_next_drive(input rnpc_state_t ns, input logic start_drive, input logic held);
    bidir_next_drive = (ns == RNPC_SEQ) && (start_drive || held);
  endfunction : bidir_next_drive

  assign reset_in_line_out = 1'b0;

  // status to the core; power-down refused with nmi high keeps running
  always_comb begin
    core_stat_out                    = '0;
    core_stat_out.core_reset         = (state == RNPC_SEQ);
    core_stat_out.nmi_trap           = nmi_trap;
    core_stat_out.power_down         = (state == RNPC_PD);     // RULE_08
    core_stat_out.bidir_reset_enable = bidir;
    core_stat_out.init_done          = init_done;
    core_stat_out.reset_cause        = cause;
    core_stat_out.cfg_latch          = cfg_latch;
    core_stat_out.boot_loader        = boot_loader;
  end

endmodule : rnpc_reset_nmi_ctrl

//--- dv/rnpc_props.sv
// rnpc_props: port-level checks of the reset / nmi / power-down controller
// assumes binding onto rnpc_reset_nmi_ctrl with one clock domain
`timescale 1ns/1ps
module rnpc_props
  import rnpc_pkg::*;
#(
  parameter int SEQ_CYC = 8,
  parameter int MIN_CYC = 4
) (
  // clock and reset
  input wire logic            sys_clk_in,
  input wire logic            nrst_in,
  // pins
  input wire logic            reset_in_line_in,
  input wire logic            reset_in_line_oe_out,
  input wire logic            reset_indication_out,
  input wire logic            nmi_in,
  // core side
  input wire rnpc_core_req_t  core_req_in,
  input wire rnpc_core_stat_t core_stat_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // consecutive external low samples, saturating at the qualification length
  int unsigned low_run;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_run <= 0;
    end else if (reset_in_line_in || reset_in_line_oe_out) begin
      low_run <= 0;
    end else if (low_run < MIN_CYC) begin
      low_run <= low_run + 1;
    end
  end

  // own drive excluded, else the line stays low as the sequence ends
  a_line_low_reset: assert property (low_run == MIN_CYC |=> core_stat_out.core_reset)
    else $error("held reset line not taken");
  a_oe_in_seq: assert property (reset_in_line_oe_out |-> core_stat_out.core_reset || $past(core_stat_out.core_reset))
    else $error("reset line driven outside sequence");
  a_ind_low_reset: assert property (core_stat_out.core_reset |-> !reset_indication_out)
    else $error("indication high during reset");
  a_ind_rise_init: assert property ($rose(reset_indication_out) |-> $past(core_req_in.end_of_init_instr))
    else $error("indication released without end of init");
  a_nmi_trap_edge: assert property (core_stat_out.nmi_trap |-> $past(nmi_in, 2) && !$past(nmi_in))
    else $error("trap without falling nmi edge");
  a_pd_nmi_low: assert property ($rose(core_stat_out.power_down) |-> !$past(nmi_in) && $past(core_req_in.power_down_instr))
    else $error("power-down entered wrongly");
  a_pd_refused: assert property (core_req_in.power_down_instr && nmi_in && !core_stat_out.power_down |=> !core_stat_out.power_down)
    else $error("power-down taken with nmi high");
  a_bidir_locked: assert property (core_stat_out.init_done && core_req_in.bidir_wr ##1 !core_stat_out.core_reset |-> $stable(core_stat_out.bidir_reset_enable))
    else $error("bidir bit written after init");
  a_bidir_clear: assert property ($rose(core_stat_out.core_reset) |=> !core_stat_out.bidir_reset_enable)
    else $error("bidir bit kept over reset");
  a_seq_length: assert property ($fell(core_stat_out.core_reset) |-> $past(core_stat_out.core_reset, SEQ_CYC))
    else $error("reset sequence too short");
endmodule : rnpc_props

bind rnpc_reset_nmi_ctrl rnpc_props #(.SEQ_CYC(SEQ_CYC), .MIN_CYC(MIN_CYC)) props_u (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reset_in_line_in(reset_in_line_in),
  .reset_in_line_oe_out(reset_in_line_oe_out), .reset_indication_out(reset_indication_out),
  .nmi_in(nmi_in), .core_req_in(core_req_in), .core_stat_out(core_stat_out)
);

//--- dv/rnpc_reset_src.sv
// rnpc_reset_src: external open-drain reset source on the shared reset line
// assumes a pull-up on the line; nobody ever drives it high
`timescale 1ns/1ps
module rnpc_reset_src (
  // clock and command
  input  wire logic       sys_clk_in,
  input  wire logic       start_in,
  input  wire logic [7:0] low_cyc_in,
  // line
  input  wire logic       dev_oe_in,
  output logic            line_out
);
  logic [7:0] cnt = 8'h00;
  // pull low for the commanded cycles; short pulses allowed on purpose
  always_ff @(posedge sys_clk_in) begin
    if (start_in) cnt <= low_cyc_in;
    else if (cnt != 8'h00) cnt <= cnt - 8'h01;
  end
  // wired-and of both open-drain pullers
  assign line_out = !(dev_oe_in || (cnt != 8'h00));
endmodule : rnpc_reset_src

//--- dv/rnpc_reset_nmi_ctrl_tb.sv
// rnpc_reset_nmi_ctrl_tb: self-checking bench for the reset / nmi / power-down controller
// assumes rnpc_reset_src on the line and the bound checker
`timescale 1ns/1ps
module rnpc_reset_nmi_ctrl_tb;
  import rnpc_pkg::*;
  localparam int SEQ = 8;
  localparam int MINC = 4;
  localparam rnpc_core_req_t SW = 6'h20, WDT = 6'h10, PD = 6'h08, EOI = 6'h04, BWR1 = 6'h03, BWR0 = 6'h02;
  logic            sys_clk_in, nrst_in, nmi_in, boot_sel, start, line, oe, ind;
  logic [7:0]      low_cyc;
  rnpc_core_req_t  req;
  rnpc_core_stat_t st;
  int              fails, cmp_count;

  rnpc_reset_nmi_ctrl #(.SEQ_CYC(SEQ), .MIN_CYC(MINC)) dut_u (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reset_in_line_in(line), .reset_in_line_out(),
    .reset_in_line_oe_out(oe), .reset_indication_out(ind), .nmi_in(nmi_in),
    .boot_select_pin_in(boot_sel), .core_req_in(req), .core_stat_out(st));
  rnpc_reset_src src_u (.sys_clk_in(sys_clk_in), .start_in(start), .low_cyc_in(low_cyc),
    .dev_oe_in(oe), .line_out(line));

  // free-running 100 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic exp_trap(input logic prev, input logic cur); return prev & ~cur; endfunction : exp_trap
  function automatic logic exp_pd(input logic nmi); return ~nmi; endfunction : exp_pd

  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // leading step keeps two pulses from writing req in one time step
  task automatic pulse(input rnpc_core_req_t r);
    step();
    req = r;
    step();
    req = '0;
  endtask : pulse
  task automatic ext_low(input logic [7:0] n);
    low_cyc = n;
    start = 1'b1;
    step();
    start = 1'b0;
    step(n + 1);
  endtask : ext_low
  task automatic wait_seq();
    int n;
    n = 0;
    while (st.core_reset !== 1'b0 && n < 200) begin
      step();
      n++;
    end
    chk(n < 200, 1'b1);
  endtask : wait_seq
  task automatic tally_and_finish();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    void'($urandom(32'hf98d));
    {nrst_in, start, low_cyc, req, fails, cmp_count} = '0;
    {nmi_in, boot_sel} = 2'b11;
    step(20);
    nrst_in = 1'b1;
    step();
    chk(st.core_reset, 1'b1);
    chk(ind, 1'b0);
    wait_seq();
    chk(st.cfg_latch, 1'b1);
    step($urandom_range(6, 1));
    chk(ind, 1'b0);
    pulse(EOI);
    chk(ind, 1'b1);
    chk(st.init_done, 1'b1);
    repeat (8) begin
      step($urandom_range(5, 1));
      nmi_in = 1'b0;
      step();
      chk(st.nmi_trap, exp_trap(1'b1, nmi_in));
      step();
      chk(st.nmi_trap, 1'b0);
      nmi_in = 1'b1;
    end
    pulse(PD);
    step();
    chk(st.power_down, exp_pd(nmi_in));
    nmi_in = 1'b0;
    pulse(PD);
    chk(st.power_down, exp_pd(nmi_in));
    nmi_in = 1'b1;
    pulse(WDT);
    chk(st.core_reset, 1'b1);
    wait_seq();
    chk(st.reset_cause, CAUSE_WDT);
    ext_low(MINC - 1);
    chk(st.core_reset, 1'b0);
    ext_low(MINC + 2);
    chk(st.core_reset, 1'b1);
    wait_seq();
    pulse(BWR1);
    chk(st.bidir_reset_enable, 1'b1);
    pulse(EOI);
    pulse(BWR0);
    chk(st.bidir_reset_enable, 1'b1);
    boot_sel = 1'b0;
    pulse(SW);
    step();
    chk(oe, 1'b1);
    wait_seq();
    chk(st.reset_cause, CAUSE_HW_LONG);
    chk(st.bidir_reset_enable, 1'b0);
    chk(st.boot_loader, 1'b1);
    boot_sel = 1'b1;
    pulse(BWR1);
    ext_low(1);
    chk(st.core_reset, 1'b1);
    wait_seq();
    tally_and_finish();
  end
endmodule : rnpc_reset_nmi_ctrl_tb
